/* rtl/link_param_capture_regs.sv */
// Read-only bank of link parameters captured from lane 0 configuration data.
// Assumes the serial control port decodes into single-cycle rd/wr strobes.
//
// Behaviour
// - Fields captured from lane 0, read-only
// - Bit 7 reports transmitter scrambling setting
// - Lane count minus one: 0,1,3,7
// - Octets per frame minus one: 0,1,3
// - Frames per multiframe minus one: 0x0F/0x1F
// - Bits 7:5 report subclass version
// - Link version 000 is A, 001 B
`timescale 1ns/100ps
module link_param_capture_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfg_start,
  input wire logic cfg_valid,
  input wire logic [7:0] cfg_octet,
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic params_ok,
  output logic link_version_b
);
  import link_param_pkg::*;

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_reg;
  logic rst_n_int;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  // ==========================================================
  // Octet numbering
  cfg_octet_if oct ();

  ilas_octet_tracker u_tracker (
    .clk_sys(clk_sys),
    .rst_n(rst_n_int),
    .cfg_start(cfg_start),
    .cfg_valid(cfg_valid),
    .cfg_octet(cfg_octet),
    .oct(oct)
  );

  // ==========================================================
  // Captured fields
  logic scramble_status_reg;
  logic [4:0] lanes_m1_reg;
  logic [7:0] frame_m1_reg;
  logic [4:0] mframe_m1_reg;
  logic [7:0] conv_m1_reg;
  logic [1:0] ctrl_bits_reg;
  logic [4:0] res_m1_reg;
  logic [2:0] subclass_version_reg;
  logic [4:0] sample_bits_m1_reg;
  logic [2:0] link_version_reg;

  // Only the lane-0 stream loads these; reg_wr has no path here
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      scramble_status_reg <= 1'b0;
      lanes_m1_reg <= 5'h00;
      frame_m1_reg <= RESET_BYTE;
      mframe_m1_reg <= 5'h00;
      conv_m1_reg <= RESET_BYTE;
      ctrl_bits_reg <= 2'h0;
      res_m1_reg <= 5'h00;
      subclass_version_reg <= 3'h0;
      sample_bits_m1_reg <= 5'h00;
      link_version_reg <= 3'h0;
    end else if (oct.wr) begin
      unique case (oct.idx)
        OCT_SCRAMBLE_LANE: begin
          scramble_status_reg <= oct.data[SCRAMBLE_BIT];
          lanes_m1_reg <= oct.data[M1_HI:0];
        end
        OCT_FRAME: frame_m1_reg <= oct.data;
        OCT_MULTIFRAME: mframe_m1_reg <= oct.data[M1_HI:0];
        OCT_CONVERTER: conv_m1_reg <= oct.data;
        OCT_CTRL_RES: begin
          ctrl_bits_reg <= oct.data[CS_HI:CS_LO];
          res_m1_reg <= oct.data[M1_HI:0];
        end
        OCT_SUBCLASS: begin
          subclass_version_reg <= oct.data[TOP3_HI:TOP3_LO];
          sample_bits_m1_reg <= oct.data[M1_HI:0];
        end
        OCT_VERSION: link_version_reg <= oct.data[TOP3_HI:TOP3_LO];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Permitted-value check
  // Flags a transmitter whose advertised setup this receiver cannot take
  logic ok_comb;
  logic params_ok_reg;
  logic version_b_reg;

  always_comb begin
    ok_comb = 1'b1;
    if (!(lanes_m1_reg inside {LANES_1, LANES_2, LANES_4, LANES_8})) ok_comb = 1'b0;
    if (!(frame_m1_reg inside {FRAME_1, FRAME_2, FRAME_4})) ok_comb = 1'b0;
    if (!(mframe_m1_reg inside {MF_16, MF_32})) ok_comb = 1'b0;
    if (!(conv_m1_reg inside {CONV_1, CONV_2})) ok_comb = 1'b0;
    if (ctrl_bits_reg != CS_NONE) ok_comb = 1'b0;
    if (res_m1_reg != RES_16) ok_comb = 1'b0;
    if (sample_bits_m1_reg != SAMPLE_16) ok_comb = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      params_ok_reg <= 1'b0;
      version_b_reg <= 1'b0;
    end else begin
      params_ok_reg <= ok_comb;
      version_b_reg <= (link_version_reg == VERSION_B);
    end
  end
  assign params_ok = params_ok_reg;
  assign link_version_b = version_b_reg;

  // ==========================================================
  // Register read port
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  // Reserved bits are forced to zero here, never stored
  always_comb begin
    unique case (reg_addr)
      ADDR_SCRAMBLE_LANE_COUNT: rdata_next = {scramble_status_reg, 2'b00, lanes_m1_reg};
      ADDR_FRAME_OCTET_COUNT: rdata_next = frame_m1_reg;
      ADDR_MULTIFRAME_LENGTH: rdata_next = {3'b000, mframe_m1_reg};
      ADDR_CONVERTER_COUNT: rdata_next = conv_m1_reg;
      ADDR_CONTROL_BITS_RESOLUTION: rdata_next = {ctrl_bits_reg, 1'b0, res_m1_reg};
      ADDR_SUBCLASS_SAMPLE_BITS: rdata_next = {subclass_version_reg, sample_bits_m1_reg};
      ADDR_LINK_VERSION: rdata_next = {link_version_reg, 5'h00};
      default: rdata_next = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rdata_reg <= RESET_BYTE;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_int);

  sequence seq_oct(logic [3:0] n);
    oct.wr && (oct.idx == n);
  endsequence

  sequence seq_read(logic [11:0] a);
    reg_rd && (reg_addr == a) && !oct.wr;
  endsequence

  chk_scramble_capture: assert property (
    seq_oct(OCT_SCRAMBLE_LANE) |=> scramble_status_reg == $past(oct.data[SCRAMBLE_BIT]))
    else $error("scramble status not captured");

  chk_lane_read: assert property (
    seq_read(ADDR_SCRAMBLE_LANE_COUNT) ##1 1'b1 |-> reg_rvalid && reg_rdata[4:0] == lanes_m1_reg)
    else $error("lane count read mismatch");

  chk_reserved_zero: assert property (
    reg_rvalid && $past(reg_addr) == ADDR_SCRAMBLE_LANE_COUNT |-> reg_rdata[6:5] == 2'b00)
    else $error("reserved bits not zero");

  chk_write_ignored: assert property (
    reg_wr && !oct.wr |=> $stable(frame_m1_reg) && $stable(conv_m1_reg) && $stable(lanes_m1_reg))
    else $error("write altered captured value");

  chk_subclass_capture: assert property (
    seq_oct(OCT_SUBCLASS) |=> subclass_version_reg == $past(oct.data[TOP3_HI:TOP3_LO]))
    else $error("subclass version not captured");

  chk_subclass_path: assert property (
    seq_read(ADDR_SUBCLASS_SAMPLE_BITS) |=> reg_rdata[7:5] == $past(subclass_version_reg))
    else $error("subclass version not reported");

  chk_read_latency: assert property (
    reg_rd |=> reg_rvalid ##1 (!reg_rvalid || $past(reg_rd)))
    else $error("read answer timing wrong");

  chk_bad_frame: assert property (
    frame_m1_reg == 8'h02 |=> !params_ok)
    else $error("illegal frame size accepted");

  chk_ctrl_bits: assert property (
    ctrl_bits_reg != CS_NONE |=> !params_ok)
    else $error("control bits accepted");

  chk_version_b: assert property (
    seq_oct(OCT_VERSION) ##1 1'b1 |=> link_version_b == ($past(oct.data[7:5], 2) == VERSION_B))
    else $error("version decode wrong");

  chk_legal_ok: assert property (
    mframe_m1_reg == MF_16 && res_m1_reg == RES_16 && sample_bits_m1_reg == SAMPLE_16 &&
    conv_m1_reg == CONV_2 && frame_m1_reg == FRAME_4 && lanes_m1_reg == LANES_8 &&
    ctrl_bits_reg == CS_NONE |=> params_ok)
    else $error("legal setup rejected");

endmodule : link_param_capture_regs

/* inc/link_param_pkg.sv */
// Constants for the lane-0 link parameter capture bank.
// Assumes 12-bit register addresses and an 8-bit register data path.
package link_param_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] ADDR_SCRAMBLE_LANE_COUNT = 12'h403;
  localparam logic [11:0] ADDR_FRAME_OCTET_COUNT = 12'h404;
  localparam logic [11:0] ADDR_MULTIFRAME_LENGTH = 12'h405;
  localparam logic [11:0] ADDR_CONVERTER_COUNT = 12'h406;
  localparam logic [11:0] ADDR_CONTROL_BITS_RESOLUTION = 12'h407;
  localparam logic [11:0] ADDR_SUBCLASS_SAMPLE_BITS = 12'h408;
  localparam logic [11:0] ADDR_LINK_VERSION = 12'h409;

  // ==========================================================
  // Position of each register's octet in the configuration stream
  localparam logic [3:0] OCT_SCRAMBLE_LANE = 4'h3;
  localparam logic [3:0] OCT_FRAME = 4'h4;
  localparam logic [3:0] OCT_MULTIFRAME = 4'h5;
  localparam logic [3:0] OCT_CONVERTER = 4'h6;
  localparam logic [3:0] OCT_CTRL_RES = 4'h7;
  localparam logic [3:0] OCT_SUBCLASS = 4'h8;
  localparam logic [3:0] OCT_VERSION = 4'h9;
  localparam logic [3:0] OCT_LAST = 4'hD;

  // ==========================================================
  // Field positions
  localparam int SCRAMBLE_BIT = 7;
  localparam int M1_HI = 4;
  localparam int CS_HI = 7;
  localparam int CS_LO = 6;
  localparam int TOP3_HI = 7;
  localparam int TOP3_LO = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==========================================================
  // Permitted encodings
  localparam logic [4:0] LANES_1 = 5'h00;
  localparam logic [4:0] LANES_2 = 5'h01;
  localparam logic [4:0] LANES_4 = 5'h03;
  localparam logic [4:0] LANES_8 = 5'h07;
  localparam logic [7:0] FRAME_1 = 8'h00;
  localparam logic [7:0] FRAME_2 = 8'h01;
  localparam logic [7:0] FRAME_4 = 8'h03;
  localparam logic [4:0] MF_16 = 5'h0F;
  localparam logic [4:0] MF_32 = 5'h1F;
  localparam logic [7:0] CONV_1 = 8'h00;
  localparam logic [7:0] CONV_2 = 8'h01;
  localparam logic [1:0] CS_NONE = 2'h0;
  localparam logic [4:0] RES_16 = 5'h0F;
  localparam logic [4:0] SAMPLE_16 = 5'h0F;
  localparam logic [2:0] VERSION_A = 3'h0;
  localparam logic [2:0] VERSION_B = 3'h1;

endpackage : link_param_pkg

/* inc/cfg_octet_if.sv */
// Carrier of indexed configuration octets from the tracker to the bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cfg_octet_if;
  logic wr;
  logic [3:0] idx;
  logic [7:0] data;
  modport src (output wr, output idx, output data);
  modport sink (input wr, input idx, input data);
endinterface : cfg_octet_if

/* rtl/ilas_octet_tracker.sv */
// Numbers the configuration octets arriving on link lane 0.
// Assumes cfg_start marks octet 0 and the stream comes from same-clock logic.
`timescale 1ns/100ps
module ilas_octet_tracker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfg_start,
  input wire logic cfg_valid,
  input wire logic [7:0] cfg_octet,
  cfg_octet_if.src oct
);
  import link_param_pkg::*;

  // ==========================================================
  // Octet counter
  logic active_reg;
  logic [3:0] count_reg;
  logic take;

  // Octets outside a started sequence are dropped, not misfiled
  assign take = cfg_valid && (cfg_start || active_reg);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
      count_reg <= 4'h0;
    end else if (cfg_valid && cfg_start) begin
      active_reg <= 1'b1;
      count_reg <= 4'h1;
    end else if (take) begin
      active_reg <= (count_reg != OCT_LAST);
      count_reg <= count_reg + 4'h1;
    end
  end

  // ==========================================================
  // Registered indexed octet
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oct.wr <= 1'b0;
      oct.idx <= 4'h0;
      oct.data <= RESET_BYTE;
    end else begin
      oct.wr <= take;
      if (take) begin
        oct.idx <= cfg_start ? 4'h0 : count_reg;
        oct.data <= cfg_octet;
      end
    end
  end

endmodule : ilas_octet_tracker

/* verification/link_cfg_tx_model.sv */
// Partner model: transmitter logic sending lane-0 configuration octets.
// Assumes the bench calls send_cfg from one process, one sequence at a time.
`timescale 1ns/100ps
module link_cfg_tx_model (
  input wire logic clk_sys,
  output logic cfg_start,
  output logic cfg_valid,
  output logic [7:0] cfg_octet
);
  initial begin
    cfg_start = 1'b0;
    cfg_valid = 1'b0;
    cfg_octet = 8'h5A;
  end

  // ==========================================================
  // Legal parameter set; reserved and out-of-scope octets stay random
  function automatic logic [111:0] build_cfg(input logic [31:0] r);
    logic [111:0] c;
    c = {r, ~r, r, r[15:0]};
    c[28:24] = 5'((6'h01 << r[3:2]) - 6'h01);
    c[39:32] = (r[5:4] == 2'h0) ? 8'h00 : (r[5] ? 8'h03 : 8'h01);
    c[44:40] = r[6] ? 5'h1F : 5'h0F;
    c[55:48] = {7'h00, r[7]};
    c[63:62] = 2'h0;
    c[60:56] = 5'h0F;
    c[68:64] = 5'h0F;
    c[79:77] = {2'h0, r[8]};
    return c;
  endfunction : build_cfg

  // ==========================================================
  // Octet stream; data line toggles when no octet is offered
  task automatic send_cfg(input logic [111:0] c, input bit with_start, input int gap);
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_sys);
      cfg_valid <= 1'b1;
      cfg_start <= with_start && (i == 0);
      cfg_octet <= c[8*i +: 8];
      repeat (gap) begin
        @(posedge clk_sys);
        cfg_valid <= 1'b0;
        cfg_start <= 1'b0;
        cfg_octet <= ~cfg_octet;
      end
    end
    @(posedge clk_sys);
    cfg_valid <= 1'b0;
    cfg_start <= 1'b0;
    cfg_octet <= ~cfg_octet;
  endtask : send_cfg
endmodule : link_cfg_tx_model

/* verification/link_param_capture_regs_tb_top.sv */
// Self-checking bench for the link parameter capture bank.
// Assumes the register strobes and the octet stream share clk_sys.
`timescale 1ns/100ps
module link_param_capture_regs_tb_top;
  import link_param_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_start, cfg_valid, reg_rd = 1'b0, reg_wr = 1'b0, reg_rvalid, params_ok, link_version_b;
  logic [7:0] cfg_octet, reg_wdata = 8'h00, reg_rdata;
  logic [11:0] reg_addr = 12'h000;
  logic [111:0] cur = '0;
  logic [31:0] seed = 32'h6146;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #25 clk_sys = ~clk_sys;

  link_cfg_tx_model u_tx (.clk_sys(clk_sys), .cfg_start(cfg_start), .cfg_valid(cfg_valid),
    .cfg_octet(cfg_octet));
  link_param_capture_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_start(cfg_start),
    .cfg_valid(cfg_valid), .cfg_octet(cfg_octet), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .params_ok(params_ok), .link_version_b(link_version_b));

  // ==========================================================
  // Expectations
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] exp_reg(input logic [111:0] c, input logic [11:0] a);
    case (a)
      ADDR_SCRAMBLE_LANE_COUNT: return {c[31], 2'h0, c[28:24]};
      ADDR_FRAME_OCTET_COUNT: return c[39:32];
      ADDR_MULTIFRAME_LENGTH: return {3'h0, c[44:40]};
      ADDR_CONVERTER_COUNT: return c[55:48];
      ADDR_CONTROL_BITS_RESOLUTION: return {c[63:62], 1'b0, c[60:56]};
      ADDR_SUBCLASS_SAMPLE_BITS: return c[71:64];
      ADDR_LINK_VERSION: return {c[79:77], 5'h00};
      default: return 8'h00;
    endcase
  endfunction : exp_reg

  function automatic logic exp_ok(input logic [111:0] c);
    return c[28:24] inside {5'h00, 5'h01, 5'h03, 5'h07} && c[39:32] inside {8'h00, 8'h01, 8'h03}
      && c[44:40] inside {5'h0F, 5'h1F} && c[55:48] < 8'h02 && c[63:62] == 2'h0
      && c[60:56] == 5'h0F && c[68:64] == 5'h0F;
  endfunction : exp_ok

  // ==========================================================
  // Compare, bus and closing tasks
  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check_byte

  task automatic check_bit(input string what, input logic e, input logic g);
    check_byte(what, {7'h00, e}, {7'h00, g});
  endtask : check_bit

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic rd_check(input logic [11:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check_bit("read valid", 1'b1, reg_rvalid);
    check_byte($sformatf("reg %h", a), exp_reg(cur, a), reg_rdata);
  endtask : rd_check

  task automatic check_all(input string name);
    repeat (3) @(posedge clk_sys);
    for (logic [11:0] a = 12'h3FF; a <= 12'h40A; a++) rd_check(a);
    check_bit("params ok", exp_ok(cur), params_ok);
    check_bit("version b", cur[79:77] == VERSION_B, link_version_b);
    $display("test %s done", name);
  endtask : check_all

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    logic [111:0] c;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    check_all("reset");
    for (int n = 0; n < 24; n++) begin
      cur = u_tx.build_cfg(rnd());
      u_tx.send_cfg(cur, 1'b1, n % 3);
      check_all("capture");
    end
    for (logic [11:0] a = ADDR_SCRAMBLE_LANE_COUNT; a <= ADDR_LINK_VERSION; a++) begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= 8'(rnd());
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
    check_all("write ignored");
    c = u_tx.build_cfg(rnd());
    u_tx.send_cfg(c, 1'b0, 0);
    check_all("no start");
    for (int k = 0; k < 7; k++) begin
      cur = u_tx.build_cfg(rnd());
      case (k)
        0: cur[28:24] = 5'h02;
        1: cur[39:32] = 8'h02;
        2: cur[44:40] = 5'h10;
        3: cur[55:48] = 8'h02;
        4: cur[63:62] = 2'h1;
        5: cur[60:56] = 5'h0E;
        default: cur[68:64] = 5'h1F;
      endcase
      u_tx.send_cfg(cur, 1'b1, 1);
      check_all("bad field");
    end
    // Mid-run reset must clear fields captured above
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    cur = '0;
    check_all("reset again");
    wrap_up();
  end
endmodule : link_param_capture_regs_tb_top
